// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vfis_pkg::*;
	localparam logic [5:0] GORD [8] = '{6'h06, 6'h18, 6'h06, 6'h12, 6'h21, 6'h24, 6'h09, 6'h06};
	logic        clk, rst_b, wr, rd, ack, busy, ge, push, pop, vrd, pld, fld, iend, ret;
	logic        ge_op, gb_op, run, do_ret, hit;
	logic [7:0]  addr, wd, rdat, req, en, mk, pclr, fl, fo, wdat, rdata, vaddr, vdata, sp, v;
	logic [2:0]  alv;
	logic [15:0] pc, pco, h;
	int          fails, check_count, cyc;
	vfis_sequencer uut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdat), .SRC_REQ(req), .SRC_ENABLE(en), .PEND_CLEAR(pclr),
		.INSTR_END(iend), .RET_STROBE(ret), .GLOBAL_ENABLE_OP(ge_op), .GLOBAL_BLOCK_OP(gb_op),
		.PC_IN(pc), .FLAGS_IN(fl), .ACK_STROBE(ack), .ACK_LEVEL(alv), .BUSY(busy),
		.GLOBAL_ENABLE(ge), .STACK_PUSH(push), .STACK_POP(pop), .STACK_WDATA(wdat),
		.STACK_RDATA(rdata), .VEC_RD(vrd), .VEC_ADDR(vaddr), .VEC_RDATA(vdata), .PC_LOAD(pld),
		.PC_OUT(pco), .FLAGS_LOAD(fld), .FLAGS_OUT(fo));
	vfis_core_model m (.clk(clk), .rst_b(rst_b), .run(run), .do_ret(do_ret), .busy(busy),
		.push(push), .pop(pop), .wdata(wdat), .rdata(rdata), .vrd(vrd), .vaddr(vaddr),
		.vdata(vdata), .pld(pld), .pcn(pco), .fld(fld), .fn(fo), .iend(iend), .ret(ret),
		.pc(pc), .flags(fl), .sp(sp));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			results();
		end
	end
	function automatic logic [2:0] win(input logic [7:0] r, input logic [7:0] p);
		logic [5:0] go;
		int gp [3];
		int rk [8];
		int best;
		logic [2:0] w;
		go = GORD[{p[7], p[4], p[1]}];
		for (int i = 0; i < 3; i++)
			gp[go[4 - 2 * i +: 2]] = i;
		rk = '{gp[0] * 4 + p[0], gp[0] * 4 + !p[0], gp[1] * 4 + 2 * p[2], gp[1] * 4 + !p[2] + p[3],
			gp[1] * 4 + !p[2] + !p[3], gp[2] * 4 + 2 * p[5], gp[2] * 4 + !p[5] + p[6],
			gp[2] * 4 + !p[5] + !p[6]};
		best = 99;
		w = 3'h0;
		for (int l = 0; l < 8; l++)
			if (r[l] && rk[l] < best)
			begin
				best = rk[l];
				w = l[2:0];
			end
		return w;
	endfunction : win
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("register", {8'h00, e}, {8'h00, rdat});
	endtask : rreg
	task automatic op(input int k);
		@(posedge clk);
		{ge_op, gb_op, do_ret} <= 3'b100 >> k;
		@(posedge clk);
		{ge_op, gb_op, do_ret} <= 3'b000;
	endtask : op
	task automatic wt(input int k);
		hit = 1'b0;
		for (int i = 0; i < 40 && !hit; i++)
		begin
			@(posedge clk);
			#1 hit = k ? busy === 1'b0 : ack === 1'b1;
		end
	endtask : wt
	task automatic serve(input logic [2:0] l, input logic fast);
		logic [7:0] a;
		a = {VECTOR_BASE[7:4], l, 1'b0};
		wt(0);
		chk("ack level", {12'h000, hit, l}, {13'h0001, alv});
		chk("pending clear", {8'h00, AUTO_CLEAR & (8'h01 << l)}, {8'h00, pclr});
		// handler clears its own bit; random runs also drop the losers
		req <= fast ? req & ~(8'h01 << l) : 8'h00;
		wt(1);
		// core takes the new pc one edge after the load strobe
		@(posedge clk);
		#1 chk("enable", 16'h0000, {15'h0000, ge});
		if (fast)
		begin
			chk("fast pc", h, pc);
			chk("fast flags", 16'h00A6, {8'h00, fl});
			chk("fast sp", 16'h0080, {8'h00, sp});
			rreg(ADDR_PTR_HIGH, 8'h12);
			rreg(ADDR_PTR_LOW, 8'h34);
		end
		else
		begin
			chk("vector", {a ^ 8'hC3, (a | 8'h01) ^ 8'hC3}, pc);
			chk("stack pc", 16'h1234, {m.mem[8'h7E], m.mem[8'h7F]});
			chk("stack flags", 16'h00A4, {8'h00, m.mem[8'h7D]});
		end
		op(2);
		repeat (8) @(posedge clk);
		#1 chk("return pc", 16'h1234, pc);
		chk("return flags", 16'h00A4, {8'h00, fl});
		chk("return enable", 16'h0001, {15'h0000, ge});
		if (fast)
		begin
			// swap back leaves the pc seen at return in the pointer
			rreg(ADDR_PTR_HIGH, h[15:8]);
			rreg(ADDR_PTR_LOW, h[7:0]);
			wreg(ADDR_PTR_HIGH, h[15:8]);
			wreg(ADDR_PTR_LOW, h[7:0]);
		end
	endtask : serve
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	initial
	begin
		{rst_b, wr, rd, ge_op, gb_op, run, do_ret, req, en, addr, wd} = '0;
		void'($urandom(32'hFCE1));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		run <= 1'b1;
		rreg(ADDR_SYS_CTRL, 8'h00);
		rreg(8'h10, 8'h00);
		wreg(ADDR_REQ_STATUS, 8'hFF);
		rreg(ADDR_REQ_STATUS, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			v = 8'($urandom);
			mk = i[0] ? 8'hFF : 8'($urandom);
			// previous return left enable set; block before new requests
			op(1);
			req <= 8'($urandom);
			en <= 8'($urandom);
			wreg(ADDR_PRIORITY, v);
			wreg(ADDR_LEVEL_MASK, mk);
			rreg(ADDR_LEVEL_MASK, mk);
			rreg(ADDR_REQ_STATUS, req & en);
			op(0);
			if ((req & en & mk) == 8'h00)
			begin
				wt(0);
				chk("masked ack", 16'h0000, {15'h0000, hit});
				op(1);
				req <= 8'h00;
			end
			else
				serve(win(req & en & mk, v), 1'b0);
		end
		wreg(ADDR_LEVEL_MASK, 8'hFF);
		en <= 8'hFF;
		for (int l = 0; l < 8; l++)
		begin
			h = {8'h80 | l[7:0], 8'h5A};
			wreg(ADDR_PTR_HIGH, h[15:8]);
			wreg(ADDR_PTR_LOW, h[7:0]);
			wreg(ADDR_SYS_CTRL, {3'b000, l[2:0], 2'b00});
			wreg(ADDR_SYS_CTRL, {3'b000, l[2:0], 2'b10});
			req <= 8'h01 << l;
			op(0);
			serve(l[2:0], 1'b1);
		end
		op(1);
		req <= 8'h80;
		wt(0);
		chk("blocked ack", 16'h0000, {15'h0000, hit});
		wreg(ADDR_SYS_CTRL, 8'h1D);
		serve(3'h7, 1'b0);
		wreg(ADDR_SYS_CTRL, 8'h00);
		wreg(ADDR_PRIORITY, 8'h00);
		req <= 8'h80;
		op(0);
		wt(0);
		chk("outer level", 16'h000F, {12'h000, hit, alv});
		req <= 8'h00;
		wt(1);
		wreg(ADDR_LEVEL_MASK, 8'h01);
		req <= 8'h81;
		op(0);
		wt(0);
		chk("nested level", 16'h0008, {12'h000, hit, alv});
		req <= 8'h00;
		wt(1);
		op(2);
		repeat (8) @(posedge clk);
		#1 chk("nested return", 16'hCDCC, pc);
		wreg(ADDR_LEVEL_MASK, 8'hFF);
		op(2);
		repeat (8) @(posedge clk);
		#1 chk("outer return", 16'h1234, pc);
		chk("outer enable", 16'h0001, {15'h0000, ge});
		results();
	end
endmodule : tb_top
`default_nettype wire

// ==== dv/vfis_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vfis_core_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        run,
	input  wire logic        do_ret,
	input  wire logic        busy,
	input  wire logic        push,
	input  wire logic        pop,
	input  wire logic [7:0]  wdata,
	output var  logic [7:0]  rdata,
	input  wire logic        vrd,
	input  wire logic [7:0]  vaddr,
	output var  logic [7:0]  vdata,
	input  wire logic        pld,
	input  wire logic [15:0] pcn,
	input  wire logic        fld,
	input  wire logic [7:0]  fn,
	output var  logic        iend,
	output var  logic        ret,
	output var  logic [15:0] pc,
	output var  logic [7:0]  flags,
	output var  logic [7:0]  sp
);
	logic [7:0] mem [256];
	always @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			{iend, ret, rdata, vdata} <= '0;
			pc <= 16'h1234;
			flags <= 8'hA4;
			sp <= 8'h80;
		end
		else
		begin
			// core stalls while busy, one-cycle instructions otherwise
			iend <= run && !busy && !do_ret;
			ret <= do_ret;
			// released lines flip so a stale byte never reads as valid
			vdata <= vrd ? vaddr ^ 8'hC3 : ~vdata;
			rdata <= pop ? mem[sp] : ~rdata;
			if (pop)
				sp <= sp + 8'h01;
			if (push)
			begin
				mem[sp - 8'h01] <= wdata;
				sp <= sp - 8'h01;
			end
			if (pld)
				pc <= pcn;
			if (fld)
				flags <= fn;
		end
endmodule : vfis_core_model
`default_nettype wire

// ==== dv/vfis_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module vfis_sva
	import vfis_pkg::*;
#(
	parameter logic [7:0] AUTO_LEVELS = AUTO_CLEAR
)
(
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        INSTR_END,
	input wire logic        RET_STROBE,
	input wire logic [15:0] PC_IN,
	input wire logic [7:0]  FLAGS_IN,
	input wire logic        ACK_STROBE,
	input wire logic [2:0]  ACK_LEVEL,
	input wire logic        BUSY,
	input wire logic        GLOBAL_ENABLE,
	input wire logic        STACK_PUSH,
	input wire logic [7:0]  STACK_WDATA,
	input wire logic        VEC_RD,
	input wire logic [7:0]  VEC_ADDR,
	input wire logic        PC_LOAD,
	input wire logic [7:0]  PEND_CLEAR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	ack_gate_a: assert property (ACK_STROBE |-> $past(GLOBAL_ENABLE))
		else $error("ack while disabled");
	ack_boundary_a: assert property (ACK_STROBE |-> $past(INSTR_END))
		else $error("ack off boundary");
	ack_idle_a: assert property (ACK_STROBE |-> !$past(BUSY))
		else $error("ack while busy");
	ge_clear_a: assert property (ACK_STROBE |-> ##[1:2] !GLOBAL_ENABLE)
		else $error("enable kept");
	push_order_a: assert property ($rose(STACK_PUSH) |-> STACK_WDATA == PC_IN[7:0]
		##1 STACK_PUSH && STACK_WDATA == PC_IN[15:8] ##1 STACK_PUSH && STACK_WDATA == FLAGS_IN)
		else $error("push order");
	vec_fetch_a: assert property ($rose(VEC_RD) |-> VEC_ADDR == {VECTOR_BASE[7:4], ACK_LEVEL, 1'b0}
		##1 VEC_RD && VEC_ADDR == {VECTOR_BASE[7:4], ACK_LEVEL, 1'b1})
		else $error("vector fetch");
	entry_len_a: assert property (ACK_STROBE |-> BUSY ##[1:16] PC_LOAD)
		else $error("entry too long");
	pend_clear_a: assert property (ACK_STROBE |-> PEND_CLEAR == (AUTO_LEVELS & (8'h01 << ACK_LEVEL)))
		else $error("pending clear");
	ret_enable_a: assert property (RET_STROBE && !BUSY |-> ##[1:6] GLOBAL_ENABLE)
		else $error("return enable");
endmodule : vfis_sva
bind vfis_sequencer vfis_sva #(.AUTO_LEVELS(AUTO_LEVELS)) u_sva (.CLK(CLK), .RST_B(RST_B),
	.INSTR_END(INSTR_END), .RET_STROBE(RET_STROBE), .PC_IN(PC_IN), .FLAGS_IN(FLAGS_IN),
	.ACK_STROBE(ACK_STROBE), .ACK_LEVEL(ACK_LEVEL), .BUSY(BUSY), .GLOBAL_ENABLE(GLOBAL_ENABLE),
	.STACK_PUSH(STACK_PUSH), .STACK_WDATA(STACK_WDATA), .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR),
	.PC_LOAD(PC_LOAD), .PEND_CLEAR(PEND_CLEAR));
`default_nettype wire

// ==== src/vfis_pkg.sv ====
// How it works
// - service needs enable, unmasked, top priority, source-enabled
// - acknowledge only at an instruction boundary
// - entry first clears the global enable bit
// - push PC low, PC high, then flags
// - fetch vector high then low, branch there
// - vectors even-aligned in 00H-0FH, high byte first
// - return pops PC and flags, re-enables globally
// - poll, check level, acknowledge, vector, keep polling
// - pending bit cleared at service start, levels 0-3 only
// - fast entry about 6, normal about 16 cycles
// - select field picks fast level, enable bit arms
// - any of eight levels may be fast
// - fast pointer pair at DAH high, DBH low
// - fast entry swaps pointer/PC, shadows flags, sets bit
// - fast return swaps back, restores flags, clears bit
// - fast path works for either pending type
// - only enable bit arms fast; global gates all
// - mask bit one enables its level
// - reset clears fast enable and global enable
// - priority bits 7,4,1 order groups, others members
// - request status readable while globally disabled
package vfis_pkg;

	localparam logic [7:0] ADDR_PTR_HIGH   = 8'hDA;
	localparam logic [7:0] ADDR_PTR_LOW    = 8'hDB;
	localparam logic [7:0] ADDR_REQ_STATUS = 8'hDC;
	localparam logic [7:0] ADDR_LEVEL_MASK = 8'hDD;
	localparam logic [7:0] ADDR_SYS_CTRL   = 8'hDE;
	localparam logic [7:0] ADDR_PRIORITY   = 8'hFF;

	// system control byte layout
	localparam int SYS_GE_BIT   = 0;
	localparam int SYS_FEN_BIT  = 1;
	localparam int SYS_FSEL_LSB = 2;

	localparam int FLAG_FAST_BIT = 1;

	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [7:0]  VECTOR_BASE   = 8'h00;
	localparam logic [7:0]  AUTO_CLEAR    = 8'h0F;

	localparam logic [4:0] NORMAL_ENTRY_CYCLES = 5'h10;
	localparam logic [4:0] FAST_ENTRY_CYCLES   = 5'h06;

	typedef enum logic [3:0]
	{
		ST_IDLE     = 4'h0,
		ST_CLR_GE   = 4'h1,
		ST_PUSH_PCL = 4'h2,
		ST_PUSH_PCH = 4'h3,
		ST_PUSH_FLG = 4'h4,
		ST_FETCH_H  = 4'h5,
		ST_FETCH_L  = 4'h6,
		ST_CAPTURE  = 4'h7,
		ST_FAST     = 4'h8,
		ST_WAIT     = 4'h9,
		ST_POP_FLG  = 4'hA,
		ST_POP_PCH  = 4'hB,
		ST_POP_PCL  = 4'hC,
		ST_POP_DONE = 4'hD
	} vfis_state_type;

endpackage : vfis_pkg

// ==== src/vfis_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module vfis_sequencer
	import vfis_pkg::*;
#(
	parameter logic [7:0] VEC_BASE   = VECTOR_BASE,
	parameter logic [7:0] AUTO_LEVELS = AUTO_CLEAR
)
(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output var  logic [7:0]  REG_RDATA,
	input  wire logic [7:0]  SRC_REQ,
	input  wire logic [7:0]  SRC_ENABLE,
	output var  logic [7:0]  PEND_CLEAR,
	input  wire logic        INSTR_END,
	input  wire logic        RET_STROBE,
	input  wire logic        GLOBAL_ENABLE_OP,
	input  wire logic        GLOBAL_BLOCK_OP,
	input  wire logic [15:0] PC_IN,
	input  wire logic [7:0]  FLAGS_IN,
	output var  logic        ACK_STROBE,
	output var  logic [2:0]  ACK_LEVEL,
	output var  logic        BUSY,
	output var  logic        GLOBAL_ENABLE,
	output var  logic        STACK_PUSH,
	output var  logic        STACK_POP,
	output var  logic [7:0]  STACK_WDATA,
	input  wire logic [7:0]  STACK_RDATA,
	output var  logic        VEC_RD,
	output var  logic [7:0]  VEC_ADDR,
	input  wire logic [7:0]  VEC_RDATA,
	output var  logic        PC_LOAD,
	output var  logic [15:0] PC_OUT,
	output var  logic        FLAGS_LOAD,
	output var  logic [7:0]  FLAGS_OUT
);

	typedef struct packed
	{
		vfis_state_type st;
		logic [4:0]     cnt;
		logic           ge;
		logic           fen;
		logic [2:0]     fsel;
		logic [7:0]     mask;
		logic [7:0]     prio;
		logic [15:0]    ptr;
		logic [7:0]     req;
		logic [7:0]     shadow;
		logic [15:0]    pc;
		logic [7:0]     flg;
		logic [2:0]     lvl;
		logic [7:0]     vhi;
		logic [7:0]     rdata;
		logic           ack;
		logic           busy;
		logic [7:0]     pclr;
		logic           push;
		logic           pop;
		logic [7:0]     wdata;
		logic           vrd;
		logic [7:0]     vaddr;
		logic           pcld;
		logic [15:0]    pcout;
		logic           flld;
		logic [7:0]     flout;
	} vfis_regs_type;

	vfis_regs_type r_ff;
	vfis_regs_type nxt_r;

	logic [1:0] rst_sync_ff;
	logic       rst_b;
	logic [3:0] winner;
	logic       fast_hit;

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	assign rst_b = rst_sync_ff[1];

	// member winners: {found, level}
	function automatic logic [3:0] pick_a(input logic [7:0] q, input logic [7:0] p);
		logic first;
		first = p[0];
		if (q[{2'h0, first}])
			pick_a = {1'b1, 2'h0, first};
		else if (q[{2'h0, ~first}])
			pick_a = {1'b1, 2'h0, ~first};
		else
			pick_a = 4'h0;
	endfunction : pick_a

	function automatic logic [3:0] pick_sub(input logic [7:0] q, input logic [2:0] top,
		input logic [2:0] lo, input logic [2:0] hi, input logic top_last, input logic sub_rev);
		logic [2:0] s1;
		logic [2:0] s2;
		s1 = sub_rev ? hi : lo;
		s2 = sub_rev ? lo : hi;
		pick_sub = 4'h0;
		if (!top_last && q[top])
			pick_sub = {1'b1, top};
		else if (q[s1])
			pick_sub = {1'b1, s1};
		else if (q[s2])
			pick_sub = {1'b1, s2};
		else if (top_last && q[top])
			pick_sub = {1'b1, top};
	endfunction : pick_sub

	// group order from bits 7,4,1; the two unused codes fall back to A>B>C
	function automatic logic [3:0] pick_level(input logic [7:0] q, input logic [7:0] p);
		logic [3:0] ga;
		logic [3:0] gb;
		logic [3:0] gc;
		logic [3:0] o1;
		logic [3:0] o2;
		logic [3:0] o3;
		ga = pick_a(q, p);
		gb = pick_sub(q, 3'h2, 3'h3, 3'h4, p[2], p[3]);
		gc = pick_sub(q, 3'h5, 3'h6, 3'h7, p[5], p[6]);
		unique case ({p[7], p[4], p[1]})
			3'h1:
			begin
				o1 = gb; o2 = gc; o3 = ga;
			end
			3'h3:
			begin
				o1 = gb; o2 = ga; o3 = gc;
			end
			3'h4:
			begin
				o1 = gc; o2 = ga; o3 = gb;
			end
			3'h5:
			begin
				o1 = gc; o2 = gb; o3 = ga;
			end
			3'h6:
			begin
				o1 = ga; o2 = gc; o3 = gb;
			end
			default:
			begin
				o1 = ga; o2 = gb; o3 = gc;
			end
		endcase
		if (o1[3])
			pick_level = o1;
		else if (o2[3])
			pick_level = o2;
		else
			pick_level = o3;
	endfunction : pick_level

	// even entries, high byte at the lower address
	function automatic logic [7:0] vector_of(input logic [2:0] lvl);
		vector_of = {VEC_BASE[7:4], lvl, 1'b0};
	endfunction : vector_of

	always_comb
	begin
		winner   = pick_level(r_ff.req & r_ff.mask & {8{r_ff.ge}}, r_ff.prio);
		fast_hit = r_ff.fen && (r_ff.fsel == winner[2:0]);
	end

	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.ack   = 1'b0;
		nxt_r.pclr  = 8'h00;
		nxt_r.push  = 1'b0;
		nxt_r.pop   = 1'b0;
		nxt_r.vrd   = 1'b0;
		nxt_r.pcld  = 1'b0;
		nxt_r.flld  = 1'b0;
		nxt_r.rdata = RST_BYTE;
		// request status follows sources regardless of global enable
		nxt_r.req = SRC_REQ & SRC_ENABLE;
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				ADDR_PTR_HIGH:   nxt_r.rdata = r_ff.ptr[15:8];
				ADDR_PTR_LOW:    nxt_r.rdata = r_ff.ptr[7:0];
				ADDR_REQ_STATUS: nxt_r.rdata = r_ff.req;
				ADDR_LEVEL_MASK: nxt_r.rdata = r_ff.mask;
				ADDR_SYS_CTRL:   nxt_r.rdata = {3'h0, r_ff.fsel, r_ff.fen, r_ff.ge};
				ADDR_PRIORITY:   nxt_r.rdata = r_ff.prio;
				default:         nxt_r.rdata = RST_BYTE;
			endcase
		end
		if (REG_WR)
		begin
			unique case (REG_ADDR)
				ADDR_PTR_HIGH:   nxt_r.ptr[15:8] = REG_WDATA;
				ADDR_PTR_LOW:    nxt_r.ptr[7:0] = REG_WDATA;
				ADDR_LEVEL_MASK: nxt_r.mask = REG_WDATA;
				ADDR_PRIORITY:   nxt_r.prio = REG_WDATA;
				ADDR_SYS_CTRL:
				begin
					nxt_r.ge   = REG_WDATA[SYS_GE_BIT];
					nxt_r.fen  = REG_WDATA[SYS_FEN_BIT];
					nxt_r.fsel = REG_WDATA[SYS_FSEL_LSB +: 3];
				end
				default:
				begin
				end
			endcase
		end
		if (GLOBAL_ENABLE_OP)
			nxt_r.ge = 1'b1;
		if (GLOBAL_BLOCK_OP)
			nxt_r.ge = 1'b0;
		if (r_ff.busy)
			nxt_r.cnt = r_ff.cnt + 5'h01;
		unique case (r_ff.st)
			ST_IDLE:
			begin
				// requests seen mid-instruction wait for the boundary
				if (INSTR_END && winner[3])
				begin
					nxt_r.ack  = 1'b1;
					nxt_r.busy = 1'b1;
					nxt_r.lvl  = winner[2:0];
					nxt_r.pc   = PC_IN;
					nxt_r.flg  = FLAGS_IN;
					nxt_r.cnt  = 5'h01;
					nxt_r.st   = ST_CLR_GE;
					// only hardware-cleared kinds; others are left to the handler
					nxt_r.pclr = AUTO_LEVELS & (8'h01 << winner[2:0]);
					if (fast_hit)
						nxt_r.st = ST_FAST;
				end
				else if (RET_STROBE && FLAGS_IN[FLAG_FAST_BIT])
				begin
					// swap back, shadow restored with the fast bit dropped
					nxt_r.pcout = r_ff.ptr;
					nxt_r.ptr   = PC_IN;
					nxt_r.flout = r_ff.shadow & ~(8'h01 << FLAG_FAST_BIT);
					nxt_r.pcld  = 1'b1;
					nxt_r.flld  = 1'b1;
					nxt_r.ge    = 1'b1;
				end
				else if (RET_STROBE)
				begin
					nxt_r.busy = 1'b1;
					nxt_r.pop  = 1'b1;
					nxt_r.st   = ST_POP_FLG;
				end
			end
			ST_CLR_GE:
			begin
				nxt_r.ge    = 1'b0;
				nxt_r.push  = 1'b1;
				nxt_r.wdata = r_ff.pc[7:0];
				nxt_r.st    = ST_PUSH_PCL;
			end
			ST_PUSH_PCL:
			begin
				nxt_r.push  = 1'b1;
				nxt_r.wdata = r_ff.pc[15:8];
				nxt_r.st    = ST_PUSH_PCH;
			end
			ST_PUSH_PCH:
			begin
				nxt_r.push  = 1'b1;
				nxt_r.wdata = r_ff.flg;
				nxt_r.st    = ST_PUSH_FLG;
			end
			ST_PUSH_FLG:
			begin
				nxt_r.vrd   = 1'b1;
				nxt_r.vaddr = vector_of(r_ff.lvl);
				nxt_r.st    = ST_FETCH_H;
			end
			ST_FETCH_H:
			begin
				nxt_r.vrd   = 1'b1;
				nxt_r.vaddr = vector_of(r_ff.lvl) | 8'h01;
				nxt_r.st    = ST_FETCH_L;
			end
			ST_FETCH_L:
			begin
				nxt_r.vhi = VEC_RDATA;
				nxt_r.st  = ST_CAPTURE;
			end
			ST_CAPTURE:
			begin
				nxt_r.pcout = {r_ff.vhi, VEC_RDATA};
				nxt_r.st    = ST_WAIT;
			end
			ST_FAST:
			begin
				// no stack traffic, so entry is much shorter
				nxt_r.ge     = 1'b0;
				nxt_r.pcout  = r_ff.ptr;
				nxt_r.ptr    = r_ff.pc;
				nxt_r.shadow = r_ff.flg;
				nxt_r.flout  = r_ff.flg | (8'h01 << FLAG_FAST_BIT);
				nxt_r.flld   = 1'b1;
				nxt_r.st     = ST_WAIT;
			end
			ST_WAIT:
			begin
				// pad so entry length is fixed per path: FAST_ENTRY_CYCLES or NORMAL_ENTRY_CYCLES
				if (r_ff.cnt >= (fast_lvl_path() ? FAST_ENTRY_CYCLES - 5'h01
					: NORMAL_ENTRY_CYCLES - 5'h01))
				begin
					nxt_r.pcld = 1'b1;
					nxt_r.busy = 1'b0;
					nxt_r.st   = ST_IDLE;
				end
			end
			ST_POP_FLG:
			begin
				nxt_r.pop = 1'b1;
				nxt_r.st  = ST_POP_PCH;
			end
			ST_POP_PCH:
			begin
				nxt_r.pop   = 1'b1;
				nxt_r.flout = STACK_RDATA;
				nxt_r.st    = ST_POP_PCL;
			end
			ST_POP_PCL:
			begin
				nxt_r.pcout[15:8] = STACK_RDATA;
				nxt_r.st          = ST_POP_DONE;
			end
			ST_POP_DONE:
			begin
				nxt_r.pcout[7:0] = STACK_RDATA;
				nxt_r.pcld       = 1'b1;
				nxt_r.flld       = 1'b1;
				nxt_r.ge         = 1'b1;
				nxt_r.busy       = 1'b0;
				nxt_r.st         = ST_IDLE;
			end
			default:
			begin
				nxt_r.busy = 1'b0;
				nxt_r.st   = ST_IDLE;
			end
		endcase
	end

	function automatic logic fast_lvl_path();
		fast_lvl_path = r_ff.fen && (r_ff.fsel == r_ff.lvl) && !r_ff.push;
	endfunction : fast_lvl_path

	always_ff @(posedge CLK or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r_ff       <= '0;
			r_ff.st    <= ST_IDLE;
		end
		else
			r_ff <= nxt_r;
	end

	assign REG_RDATA     = r_ff.rdata;
	assign PEND_CLEAR    = r_ff.pclr;
	assign ACK_STROBE    = r_ff.ack;
	assign ACK_LEVEL     = r_ff.lvl;
	assign BUSY          = r_ff.busy;
	assign GLOBAL_ENABLE = r_ff.ge;
	assign STACK_PUSH    = r_ff.push;
	assign STACK_POP     = r_ff.pop;
	assign STACK_WDATA   = r_ff.wdata;
	assign VEC_RD        = r_ff.vrd;
	assign VEC_ADDR      = r_ff.vaddr;
	assign PC_LOAD       = r_ff.pcld;
	assign PC_OUT        = r_ff.pcout;
	assign FLAGS_LOAD    = r_ff.flld;
	assign FLAGS_OUT     = r_ff.flout;

endmodule : vfis_sequencer

`default_nettype wire
